// file: rtl/rhs_pkg.sv
package rhs_pkg;

  // register addresses of the upper bank
  localparam logic [6:0] ADDR_TX_RATE_LOW = 7'h6f;
  localparam logic [6:0] ADDR_MOD_CTRL_A = 7'h70;
  localparam logic [6:0] ADDR_MOD_CTRL_B = 7'h71;
  localparam logic [6:0] ADDR_DEVIATION_LOW = 7'h72;
  localparam logic [6:0] ADDR_OFFSET_LOW = 7'h73;
  localparam logic [6:0] ADDR_OFFSET_HIGH = 7'h74;
  localparam logic [6:0] ADDR_BAND_SELECT = 7'h75;
  localparam logic [6:0] ADDR_CARRIER_HIGH = 7'h76;
  localparam logic [6:0] ADDR_CARRIER_LOW = 7'h77;
  localparam logic [6:0] ADDR_HOLE_A = 7'h78;
  localparam logic [6:0] ADDR_HOP_CHANNEL = 7'h79;
  localparam logic [6:0] ADDR_HOP_STEP = 7'h7a;
  localparam logic [6:0] ADDR_HOLE_B = 7'h7b;
  localparam logic [6:0] ADDR_TX_FULL_LEVEL = 7'h7c;
  localparam logic [6:0] ADDR_TX_EMPTY_LEVEL = 7'h7d;
  localparam logic [6:0] ADDR_RX_FULL_LEVEL = 7'h7e;
  localparam logic [6:0] ADDR_QUEUE_PORT = 7'h7f;

  // bank spans the first address up to the queue port
  localparam int BANK_DEPTH = 17;

  // values after reset (and after power-off)
  localparam logic [7:0] RST_TX_RATE_LOW = 8'h3d;
  localparam logic [7:0] RST_MOD_CTRL_A = 8'h0c;
  localparam logic [7:0] RST_MOD_CTRL_B = 8'h00;
  localparam logic [7:0] RST_DEVIATION_LOW = 8'h20;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_BAND_SELECT = 8'h75;
  localparam logic [7:0] RST_CARRIER_HIGH = 8'hbb;
  localparam logic [7:0] RST_CARRIER_LOW = 8'h80;
  localparam logic [7:0] RST_HOP = 8'h00;
  localparam logic [7:0] RST_TX_FULL_LEVEL = 8'h37;
  localparam logic [7:0] RST_TX_EMPTY_LEVEL = 8'h04;
  localparam logic [7:0] RST_RX_FULL_LEVEL = 8'h37;
  localparam logic [7:0] RST_NONE = 8'h00;

  // implemented bits per register; others read zero
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_MOD_CTRL_A = 8'h3f;
  localparam logic [7:0] MASK_OFFSET_HIGH = 8'h03;
  localparam logic [7:0] MASK_BAND_SELECT = 8'h7f;
  localparam logic [7:0] MASK_LEVEL = 8'h3f;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // field positions
  localparam int MODA_WHITEN_BIT = 0;
  localparam int MODA_MANCH_BIT = 1;
  localparam int MODA_MANINV_BIT = 2;
  localparam int MODA_PRE_POL_BIT = 3;
  localparam int MODA_PH_PWDN_BIT = 4;
  localparam int MODA_RATE_SCALE_BIT = 5;
  localparam int MODB_DEV_MSB_BIT = 2;
  localparam int BAND_HIGH_BIT = 5;
  localparam int BAND_SIDE_BIT = 6;
  localparam int CMD_WRITE_BIT = 7;

  // serial framing
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SYNC_STAGES = 2;

  // general-purpose pin function codes
  localparam logic [4:0] GPF_POR = 5'h00;
  localparam logic [4:0] GPF_WAKEUP = 5'h01;
  localparam logic [4:0] GPF_LOW_BATT = 5'h02;
  localparam logic [4:0] GPF_CLOCK = 5'h03;
  localparam logic [4:0] GPF_TX_FULL = 5'h04;
  localparam logic [4:0] GPF_TX_EMPTY = 5'h05;
  localparam logic [4:0] GPF_RX_FULL = 5'h06;
  localparam int GPIO_COUNT = 3;

  // one received byte handed across from the link clock
  typedef struct packed {
    logic is_cmd;
    logic [7:0] data;
  } rhs_xfer_t;

  // sources a general-purpose pin may show
  typedef struct packed {
    logic por;
    logic wakeup;
    logic low_batt;
    logic clock_out;
  } rhs_gpio_src_t;

  // decoded configuration toward the radio core
  typedef struct packed {
    logic [7:0] tx_rate_low;
    logic [5:0] mod_ctrl_a;
    logic [7:0] mod_ctrl_b;
    logic [8:0] deviation_value;
    logic [9:0] offset_value;
    logic side_band;
    logic high_band;
    logic [4:0] band_number;
    logic [15:0] carrier_value;
    logic [7:0] hop_channel;
    logic [7:0] hop_step;
    logic [5:0] tx_full_level;
    logic [5:0] tx_empty_level;
    logic [5:0] rx_full_level;
  } rhs_cfg_t;

  // access phase of a select frame
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ
  } rhs_phase_t;

endpackage

// file: rtl/rhs_sync.sv
// two-stage level synchroniser, one lane per bit
module rhs_sync
  import rhs_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // foreign-domain levels
  input wire logic [W-1:0] i_async,
  // synchronised levels
  output logic [W-1:0] o_sync
);

  logic [W-1:0] stage [SYNC_STAGES]; // stage 0 feeds stage 1 only

  // plain shift chain, nothing taps the first stage
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      for (int k = 0; k < SYNC_STAGES; k++)
        stage[k] <= INIT;
    end
    else
    begin
      stage[0] <= i_async;
      for (int k = 1; k < SYNC_STAGES; k++)
        stage[k] <= stage[k-1];
    end
  end

  assign o_sync = stage[SYNC_STAGES-1];

endmodule

// file: rtl/rhs_port.sv
// Functional notes
// - input bit sampled on serial clock rise
// - select frames access; held select means burst
// - read access shifts register out serially
// - interrupt pin low on enabled event
// - shutdown high returns all registers to their reset values
// - each general pin shows configured function
// - carrier is 16 bits, resets BBh/80h
// - deviation 9 bits, msb in control b
// - control a bit enables, resets 0Ch
// - band register: side, high, 5-bit number
// - hop channel and step reset zero
module rhs_port
  import rhs_pkg::*;
(
  // system clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // serial link, clocked by the host
  input wire logic i_sclk,
  input wire logic i_port_select_n,
  input wire logic i_sdi,
  output logic o_sdo,
  // mode pins
  input wire logic i_power_off_in,
  input wire logic i_tx_select_n,
  input wire logic i_rx_select_n,
  // pins toward the host
  output logic o_irq_out_n,
  output logic [GPIO_COUNT-1:0] o_gpio,
  // radio core status
  input wire logic i_irq_pending,
  input wire logic [GPIO_COUNT-1:0][4:0] i_gpio_cfg,
  input wire rhs_gpio_src_t i_gpio_src,
  input wire logic [6:0] i_tx_fill,
  input wire logic [6:0] i_rx_fill,
  input wire logic [7:0] i_rx_data,
  // radio core control
  output logic o_tx_push,
  output logic [7:0] o_tx_data,
  output logic o_rx_pop,
  output rhs_cfg_t o_cfg,
  output logic o_power_down,
  output logic o_tx_mode,
  output logic o_rx_mode
);

  // bank index of an address, only meaningful inside the bank
  function automatic logic [4:0] bank_index(input logic [6:0] addr);
    logic [6:0] diff;
    diff = addr - ADDR_TX_RATE_LOW;
    return diff[4:0];
  endfunction

  // true when the address holds a stored byte
  function automatic logic in_bank(input logic [6:0] addr);
    return (addr >= ADDR_TX_RATE_LOW) && (addr < ADDR_QUEUE_PORT);
  endfunction

  // implemented bits of each address
  function automatic logic [7:0] bank_mask(input logic [6:0] addr);
    if (addr == ADDR_MOD_CTRL_A)
      return MASK_MOD_CTRL_A;
    else if (addr == ADDR_OFFSET_HIGH)
      return MASK_OFFSET_HIGH;
    else if (addr == ADDR_BAND_SELECT)
      return MASK_BAND_SELECT;
    else if (addr == ADDR_TX_FULL_LEVEL || addr == ADDR_TX_EMPTY_LEVEL ||
             addr == ADDR_RX_FULL_LEVEL)
      return MASK_LEVEL;
    else if (addr == ADDR_HOLE_A || addr == ADDR_HOLE_B || !in_bank(addr))
      return MASK_NONE;
    else
      return MASK_FULL;
  endfunction

  // value after reset of each address
  function automatic logic [7:0] bank_reset(input logic [6:0] addr);
    if (addr == ADDR_TX_RATE_LOW)
      return RST_TX_RATE_LOW;
    else if (addr == ADDR_MOD_CTRL_A)
      return RST_MOD_CTRL_A;
    else if (addr == ADDR_MOD_CTRL_B)
      return RST_MOD_CTRL_B;
    else if (addr == ADDR_DEVIATION_LOW)
      return RST_DEVIATION_LOW;
    else if (addr == ADDR_OFFSET_LOW || addr == ADDR_OFFSET_HIGH)
      return RST_OFFSET;
    else if (addr == ADDR_BAND_SELECT)
      return RST_BAND_SELECT;
    else if (addr == ADDR_CARRIER_HIGH)
      return RST_CARRIER_HIGH;
    else if (addr == ADDR_CARRIER_LOW)
      return RST_CARRIER_LOW;
    else if (addr == ADDR_HOP_CHANNEL || addr == ADDR_HOP_STEP)
      return RST_HOP;
    else if (addr == ADDR_TX_FULL_LEVEL)
      return RST_TX_FULL_LEVEL;
    else if (addr == ADDR_TX_EMPTY_LEVEL)
      return RST_TX_EMPTY_LEVEL;
    else if (addr == ADDR_RX_FULL_LEVEL)
      return RST_RX_FULL_LEVEL;
    else
      return RST_NONE;
  endfunction

  // burst step: the queue port never advances
  function automatic logic [6:0] step_addr(input logic [6:0] addr);
    return (addr == ADDR_QUEUE_PORT) ? addr : addr + 7'h01;
  endfunction

  // link-clock side, cleared while select is high except xfer
  logic [2:0] bit_cnt; // bit position within byte
  logic [6:0] in_shift; // first seven bits of the byte
  logic got_cmd; // command byte already taken
  logic byte_tgl; // flips on every completed byte
  rhs_xfer_t xfer; // last completed byte, held stable
  logic [7:0] out_shift; // read data going out
  logic [2:0] next_bit_cnt;
  logic [6:0] next_in_shift;
  logic next_got_cmd;
  logic next_byte_tgl;
  rhs_xfer_t next_xfer;
  logic [7:0] next_out_shift;

  // system side
  logic [7:0] bank [BANK_DEPTH]; // stored registers
  logic [7:0] next_bank [BANK_DEPTH];
  rhs_phase_t phase; // frame access phase
  rhs_phase_t next_phase;
  logic [6:0] addr; // current register address
  logic [6:0] next_addr;
  logic seen_tgl; // last byte toggle consumed
  logic next_seen_tgl;
  logic [7:0] rd_word; // read data offered to the link
  logic [7:0] next_rd_word;
  logic next_tx_push;
  logic [7:0] next_tx_data;
  logic next_rx_pop;
  logic next_irq_out_n;
  logic [GPIO_COUNT-1:0] next_gpio;
  logic next_tx_mode;
  logic next_rx_mode;

  // synchronised foreign levels
  logic tgl_s;
  logic sel_n_s;
  logic power_s;
  logic tx_sel_n_s;
  logic rx_sel_n_s;

  // shift in on each rising serial clock edge
  always_comb
  begin
    next_bit_cnt = bit_cnt + 3'h1;
    next_in_shift = {in_shift[5:0], i_sdi};
    next_got_cmd = got_cmd;
    next_byte_tgl = byte_tgl;
    next_xfer = xfer;
    if (bit_cnt == LAST_BIT)
    begin
      // byte complete: publish and flag it
      next_xfer.is_cmd = !got_cmd;
      next_xfer.data = {in_shift, i_sdi};
      next_byte_tgl = !byte_tgl;
      next_got_cmd = 1'b1; // further bytes are burst data
    end
  end

  // select high ends the frame at once
  always_ff @(posedge i_sclk or posedge i_port_select_n)
  begin
    if (i_port_select_n)
    begin
      bit_cnt <= '0;
      in_shift <= '0;
      got_cmd <= 1'b0;
      byte_tgl <= 1'b0;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      in_shift <= next_in_shift;
      got_cmd <= next_got_cmd;
      byte_tgl <= next_byte_tgl;
    end
  end

  // data word has no reset so a late select cannot wipe it
  always_ff @(posedge i_sclk)
  begin
    xfer <= next_xfer;
  end

  // load read data at each byte start after the command
  always_comb
  begin
    if (bit_cnt == '0 && got_cmd)
      next_out_shift = rd_word; // quasi-static, settled long before
    else
      next_out_shift = {out_shift[6:0], 1'b0};
  end

  // output changes on falling edges so the host samples on rising
  always_ff @(negedge i_sclk or posedge i_port_select_n)
  begin
    if (i_port_select_n)
      out_shift <= '0;
    else
      out_shift <= next_out_shift;
  end

  assign o_sdo = out_shift[7];

  // bring link and pin levels into the system clock
  rhs_sync #(
    .W(5),
    .INIT(5'h0b)
  ) u_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async({byte_tgl, i_port_select_n, i_power_off_in,
              i_tx_select_n, i_rx_select_n}),
    .o_sync({tgl_s, sel_n_s, power_s, tx_sel_n_s, rx_sel_n_s})
  );

  // register access and pin logic
  always_comb
  begin
    next_bank = bank;
    next_phase = phase;
    next_addr = addr;
    next_seen_tgl = seen_tgl;
    next_rd_word = rd_word;
    next_tx_push = 1'b0;
    next_tx_data = o_tx_data;
    next_rx_pop = 1'b0;
    if (power_s)
    begin
      // shutdown loses every register
      for (int k = 0; k < BANK_DEPTH; k++)
        next_bank[k] = bank_reset(ADDR_TX_RATE_LOW + 7'(k));
      next_phase = PH_IDLE;
      next_seen_tgl = tgl_s;
      next_rd_word = '0;
    end
    else if (sel_n_s)
    begin
      // frame over first: the toggle clear at select high is no byte
      next_phase = PH_IDLE;
      next_seen_tgl = tgl_s;
    end
    else if (tgl_s != seen_tgl)
    begin
      // a byte arrived; the last one lands before select rises
      next_seen_tgl = tgl_s;
      if (xfer.is_cmd)
      begin
        next_addr = xfer.data[6:0];
        next_phase = xfer.data[CMD_WRITE_BIT] ? PH_WRITE : PH_READ;
        if (!xfer.data[CMD_WRITE_BIT])
        begin
          if (xfer.data[6:0] == ADDR_QUEUE_PORT)
            next_rd_word = i_rx_data; // popped once sent
          else
            next_rd_word = bank[bank_index(xfer.data[6:0])] &
                           bank_mask(xfer.data[6:0]);
        end
      end
      else if (phase == PH_WRITE)
      begin
        if (addr == ADDR_QUEUE_PORT)
        begin
          next_tx_push = 1'b1;
          next_tx_data = xfer.data;
        end
        else if (in_bank(addr))
          next_bank[bank_index(addr)] =
            (xfer.data & bank_mask(addr)) |
            (bank[bank_index(addr)] & ~bank_mask(addr));
        next_addr = step_addr(addr);
      end
      else if (phase == PH_READ)
      begin
        // fetch the following register of the burst
        next_rx_pop = (addr == ADDR_QUEUE_PORT); // sent byte gone
        next_addr = step_addr(addr);
        if (step_addr(addr) == ADDR_QUEUE_PORT)
          next_rd_word = i_rx_data;
        else
          next_rd_word = bank[bank_index(step_addr(addr))] &
                         bank_mask(step_addr(addr));
      end
    end
    else if (phase == PH_READ && addr == ADDR_QUEUE_PORT)
    begin
      // track the head after each pop; it must settle before the fall
      next_rd_word = i_rx_data;
    end
    // interrupt pin follows the enabled events
    next_irq_out_n = !i_irq_pending;
    // general pins by configured function
    for (int g = 0; g < GPIO_COUNT; g++)
    begin
      case (i_gpio_cfg[g])
        GPF_POR: next_gpio[g] = i_gpio_src.por;
        GPF_WAKEUP: next_gpio[g] = i_gpio_src.wakeup;
        GPF_LOW_BATT: next_gpio[g] = i_gpio_src.low_batt;
        GPF_CLOCK: next_gpio[g] = i_gpio_src.clock_out;
        GPF_TX_FULL: next_gpio[g] = i_tx_fill >= {1'b0, o_cfg.tx_full_level};
        GPF_TX_EMPTY:
          next_gpio[g] = i_tx_fill <= {1'b0, o_cfg.tx_empty_level};
        GPF_RX_FULL: next_gpio[g] = i_rx_fill >= {1'b0, o_cfg.rx_full_level};
        default: next_gpio[g] = 1'b0;
      endcase
    end
    // mode pins as driven by the host
    next_tx_mode = !tx_sel_n_s && rx_sel_n_s;
    next_rx_mode = !rx_sel_n_s && tx_sel_n_s;
  end

  // registers of the system side
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      for (int k = 0; k < BANK_DEPTH; k++)
        bank[k] <= bank_reset(ADDR_TX_RATE_LOW + 7'(k));
      phase <= PH_IDLE;
      addr <= '0;
      seen_tgl <= 1'b0;
      rd_word <= '0;
      o_tx_push <= 1'b0;
      o_tx_data <= '0;
      o_rx_pop <= 1'b0;
      o_irq_out_n <= 1'b1;
      o_gpio <= '0;
      o_power_down <= 1'b0;
      o_tx_mode <= 1'b0;
      o_rx_mode <= 1'b0;
    end
    else
    begin
      bank <= next_bank;
      phase <= next_phase;
      addr <= next_addr;
      seen_tgl <= next_seen_tgl;
      rd_word <= next_rd_word;
      o_tx_push <= next_tx_push;
      o_tx_data <= next_tx_data;
      o_rx_pop <= next_rx_pop;
      o_irq_out_n <= next_irq_out_n;
      o_gpio <= next_gpio;
      o_power_down <= power_s;
      o_tx_mode <= next_tx_mode;
      o_rx_mode <= next_rx_mode;
    end
  end

  // configuration fields straight from stored bytes
  always_comb
  begin
    o_cfg.tx_rate_low = bank[bank_index(ADDR_TX_RATE_LOW)];
    o_cfg.mod_ctrl_a = bank[bank_index(ADDR_MOD_CTRL_A)][5:0];
    o_cfg.mod_ctrl_b = bank[bank_index(ADDR_MOD_CTRL_B)];
    o_cfg.deviation_value = {
      bank[bank_index(ADDR_MOD_CTRL_B)][MODB_DEV_MSB_BIT],
      bank[bank_index(ADDR_DEVIATION_LOW)]};
    o_cfg.offset_value = {bank[bank_index(ADDR_OFFSET_HIGH)][1:0],
                          bank[bank_index(ADDR_OFFSET_LOW)]};
    o_cfg.side_band = bank[bank_index(ADDR_BAND_SELECT)][BAND_SIDE_BIT];
    o_cfg.high_band = bank[bank_index(ADDR_BAND_SELECT)][BAND_HIGH_BIT];
    o_cfg.band_number = bank[bank_index(ADDR_BAND_SELECT)][4:0];
    o_cfg.carrier_value = {bank[bank_index(ADDR_CARRIER_HIGH)],
                           bank[bank_index(ADDR_CARRIER_LOW)]};
    o_cfg.hop_channel = bank[bank_index(ADDR_HOP_CHANNEL)];
    o_cfg.hop_step = bank[bank_index(ADDR_HOP_STEP)];
    o_cfg.tx_full_level = bank[bank_index(ADDR_TX_FULL_LEVEL)][5:0];
    o_cfg.tx_empty_level = bank[bank_index(ADDR_TX_EMPTY_LEVEL)][5:0];
    o_cfg.rx_full_level = bank[bank_index(ADDR_RX_FULL_LEVEL)][5:0];
  end

endmodule

// file: dv/rhs_port_props.sv
// protocol watcher on the port block pins
module rhs_port_props
  import rhs_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // watched inputs
  input wire logic i_port_select_n,
  input wire logic i_power_off_in,
  input wire logic i_tx_select_n,
  input wire logic i_rx_select_n,
  input wire logic i_irq_pending,
  input wire logic [GPIO_COUNT-1:0][4:0] i_gpio_cfg,
  input wire rhs_gpio_src_t i_gpio_src,
  // watched outputs
  input wire logic o_sdo,
  input wire logic o_irq_out_n,
  input wire logic [GPIO_COUNT-1:0] o_gpio,
  input wire logic o_tx_push,
  input wire logic o_rx_pop,
  input wire rhs_cfg_t o_cfg,
  input wire logic o_power_down,
  input wire logic o_tx_mode,
  input wire logic o_rx_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // single domain, so one clock and one disable
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  // past guard skips the edge right after reset
  a_irq_follows_pending: assert property (
    !$past(i_srst) |-> o_irq_out_n == !$past(i_irq_pending))
    else $error("irq pin does not follow pending");
  // mode pins pass a two-flop sync plus a register
  a_tx_mode_set: assert property (
    (!i_tx_select_n && i_rx_select_n) [*4] |=> o_tx_mode && !o_rx_mode)
    else $error("transmit mode not decoded");
  a_rx_mode_set: assert property (
    (!i_rx_select_n && i_tx_select_n) [*4] |=> o_rx_mode && !o_tx_mode)
    else $error("receive mode not decoded");
  a_power_follows: assert property (
    i_power_off_in [*4] |=> o_power_down)
    else $error("power off not seen");
  a_power_defaults: assert property (
    o_power_down [*3] |-> o_cfg.carrier_value == 16'hbb80
      && o_cfg.hop_channel == 8'h00)
    else $error("bank not at defaults while off");
  a_push_single: assert property (
    o_tx_push |=> !o_tx_push)
    else $error("push wider than one cycle");
  a_pop_single: assert property (
    o_rx_pop |=> !o_rx_pop)
    else $error("pop wider than one cycle");
  a_sdo_quiet_idle: assert property (
    i_port_select_n [*2] |-> !o_sdo)
    else $error("read line busy while deselected");
  a_gpio_por_func: assert property (
    i_gpio_cfg[0] == GPF_POR |=> o_gpio[0] == $past(i_gpio_src.por))
    else $error("pin zero does not show reset source");
  // main traffic kinds
  c_push_seen: cover property (o_tx_push);
  c_pop_seen: cover property (o_rx_pop);
  c_power_seen: cover property (o_power_down);
endmodule
bind rhs_port rhs_port_props u_props (.i_clock, .i_srst, .i_port_select_n,
  .i_power_off_in, .i_tx_select_n, .i_rx_select_n, .i_irq_pending,
  .i_gpio_cfg, .i_gpio_src, .o_sdo, .o_irq_out_n, .o_gpio, .o_tx_push,
  .o_rx_pop, .o_cfg, .o_power_down, .o_tx_mode, .o_rx_mode);

// file: dv/rhs_host_model.sv
// host side of the serial link; clock parked low between frames
module rhs_host_model
(
  // serial link toward the device
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5; // half of the 125 ns link period
  // idle: deselected, clock low
  initial
  begin
    o_sclk = 1'b0;
    o_sel_n = 1'b0;
    o_sdi = 1'b0;
    // one clean rising select edge clears the link side
    #1 o_sel_n = 1'b1;
  end
  // select falls one and a half link periods before the first rise
  task automatic open_f();
    o_sel_n = 1'b0;
    #(2 * HALF);
  endtask
  // one byte msb first; read bit taken at each rise
  task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      o_sdi = w[i];
      #HALF o_sclk = 1'b1;
      r[i] = i_sdo;
      #HALF o_sclk = 1'b0;
    end
    // released line shows the inverse so stale bits never pass
    o_sdi = ~w[0];
  endtask
  // select stays low well past the system settle time
  task automatic close_f();
    #100 o_sel_n = 1'b1;
    #100;
  endtask
endmodule

// file: dv/testbench.sv
module testbench;
  import rhs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // defaults and readable masks for 6f..7e
  localparam logic [7:0] DEF [16] = '{8'h3d, 8'h0c, 8'h00, 8'h20, 8'h00,
    8'h00, 8'h75, 8'hbb, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h37, 8'h04,
    8'h37};
  localparam logic [7:0] MSK [16] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'hff,
    8'h03, 8'h7f, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h3f, 8'h3f,
    8'h3f};
  localparam logic [7:0] FLD [8] = '{8'h21, 8'h04, 8'ha5, 8'h00, 8'h00,
    8'h4a, 8'h12, 8'h34};
  localparam logic [7:0] GEXP = 8'h15; // pin level per code
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic sclk, sel_n, sdi, sdo, irq_n, push, pop, pdn, txm, rxm;
  logic pwr_off = 1'b0;
  logic tx_n = 1'b1;
  logic rx_n = 1'b1;
  logic pend = 1'b0;
  logic [GPIO_COUNT-1:0][4:0] gcfg = '0;
  rhs_gpio_src_t gsrc = '0;
  logic [6:0] txf = '0;
  logic [6:0] rxf = '0;
  logic [7:0] rxd = '0;
  logic [7:0] txd, last_push;
  logic [GPIO_COUNT-1:0] gpio;
  rhs_cfg_t cfg;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_push = 0;
  int n_pop = 0;
  always #4 i_clock = ~i_clock;
  rhs_host_model host (.o_sclk(sclk), .o_sel_n(sel_n), .o_sdi(sdi),
    .i_sdo(sdo));
  rhs_port uut (.i_clock(i_clock), .i_srst(i_srst), .i_sclk(sclk),
    .i_port_select_n(sel_n), .i_sdi(sdi), .o_sdo(sdo),
    .i_power_off_in(pwr_off), .i_tx_select_n(tx_n), .i_rx_select_n(rx_n),
    .o_irq_out_n(irq_n), .o_gpio(gpio), .i_irq_pending(pend),
    .i_gpio_cfg(gcfg), .i_gpio_src(gsrc), .i_tx_fill(txf),
    .i_rx_fill(rxf), .i_rx_data(rxd), .o_tx_push(push), .o_tx_data(txd),
    .o_rx_pop(pop), .o_cfg(cfg), .o_power_down(pdn), .o_tx_mode(txm),
    .o_rx_mode(rxm));
  // queue strobes counted here; also the hang limit
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (push === 1'b1)
      n_push <= n_push + 1;
    if (push === 1'b1)
      last_push <= txd;
    if (pop === 1'b1)
      n_pop <= n_pop + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.open_f();
    host.xbyte({1'b1, a}, r);
    host.xbyte(d, r);
    host.close_f();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] r;
    host.open_f();
    host.xbyte({1'b0, a}, r);
    host.xbyte(8'h00, d);
    host.close_f();
  endtask
  // one burst read over 6f..7e against a table
  task automatic rdall(input logic [7:0] t [16]);
    logic [7:0] r;
    host.open_f();
    host.xbyte(8'h6f, r);
    for (int i = 0; i < 16; i++)
    begin
      host.xbyte(8'h00, r);
      chk(16'(r), 16'(t[i]));
    end
    host.close_f();
  endtask
  task automatic t_fields();
    logic [7:0] r;
    host.open_f();
    host.xbyte(8'hf0, r);
    for (int i = 0; i < 8; i++)
      host.xbyte(FLD[i], r);
    host.close_f();
    chk(16'(cfg.mod_ctrl_a), 16'h0021);
    chk(16'(cfg.deviation_value), 16'h01a5);
    chk(16'({cfg.side_band, cfg.high_band, cfg.band_number}), 16'h004a);
    chk(cfg.carrier_value, 16'h1234);
  endtask
  task automatic t_pins();
    logic [7:0] r;
    logic [1:0] p;
    @(negedge i_clock);
    pend = 1'b1;
    repeat (2) @(negedge i_clock);
    chk(16'(irq_n), 16'h0000);
    rd(7'h03, r);
    chk(16'(r), 16'h0000);
    rd(7'h04, r);
    chk(16'(r), 16'h0000);
    @(negedge i_clock);
    pend = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      p = 2'(m);
      {tx_n, rx_n} = p;
      repeat (5) @(negedge i_clock);
      chk(16'({txm, rxm}), 16'({!p[1] && p[0], !p[0] && p[1]}));
    end
    chk(16'(irq_n), 16'h0001);
    gsrc = 4'ha;
    txf = 7'h37;
    rxf = 7'h36;
    for (int c = 0; c < 8; c++)
    begin
      gcfg = {GPIO_COUNT{5'(c)}};
      repeat (2) @(negedge i_clock);
      chk(16'(gpio), 16'({GPIO_COUNT{GEXP[c]}}));
    end
  endtask
  task automatic t_queue();
    logic [7:0] r, r2;
    host.open_f();
    host.xbyte(8'hff, r);
    host.xbyte(8'h11, r);
    host.xbyte(8'h3c, r);
    host.close_f();
    chk(16'(n_push), 16'h0002);
    chk(16'(last_push), 16'h003c);
    @(negedge i_clock);
    rxd = 8'h96;
    host.open_f();
    host.xbyte(8'h7f, r);
    host.xbyte(8'h00, r);
    host.xbyte(8'h00, r2);
    host.close_f();
    chk(16'({r, r2}), 16'h9696);
    chk(16'(n_pop), 16'h0002);
  endtask
  task automatic t_mask();
    logic [7:0] r;
    host.open_f();
    host.xbyte(8'hef, r);
    for (int i = 0; i < 16; i++)
      host.xbyte(8'hff, r);
    host.close_f();
    rdall(MSK);
    wr(7'h10, 8'h5a);
    rd(7'h10, r);
    chk(16'(r), 16'h0000);
  endtask
  task automatic t_power();
    @(negedge i_clock);
    pwr_off = 1'b1;
    repeat (10) @(negedge i_clock);
    chk(16'(pdn), 16'h0001);
    pwr_off = 1'b0;
    repeat (6) @(negedge i_clock);
    chk(cfg.carrier_value, 16'hbb80);
    rdall(DEF);
  endtask
  // reset, then each scenario in turn
  initial
  begin
    repeat (6) @(negedge i_clock);
    i_srst = 1'b0;
    repeat (4) @(negedge i_clock);
    rdall(DEF);
    t_fields();
    t_pins();
    t_queue();
    t_mask();
    t_power();
    complete_run();
  end
endmodule
